// ===== verilog/kltc_defs.svh
// constants for the link-training control and status register bank
// assumes word-addressed register port, 32-bit data
`ifndef KLTC_DEFS_SVH
`define KLTC_DEFS_SVH

// ************************************************************
// register word addresses
// ************************************************************
`define KLTC_ADDR_W        8
`define KLTC_OFF_CFG       8'hd0
`define KLTC_OFF_CMD       8'hd1
`define KLTC_OFF_STAT      8'hd2
`define KLTC_OFF_WIN       8'hd3
`define KLTC_OFF_UPD       8'hd4

// ************************************************************
// configuration word fields
// ************************************************************
`define KLTC_CFG_POVR      16
`define KLTC_CFG_LOVR      17
`define KLTC_CFG_CTLE_LO   20
`define KLTC_CFG_CTLE_HI   22
`define KLTC_CFG_SWING     23
`define KLTC_CFG_DFE_LO    24
`define KLTC_CFG_DFE_HI    26
`define KLTC_CFG_MAXEQ     28
`define KLTC_CFG_PSTEP_LO  29
`define KLTC_CFG_PSTEP_HI  31
`define KLTC_CFG_RST       32'h0000_0000

// ************************************************************
// command strobe bits
// ************************************************************
`define KLTC_CMD_RESTART   0
`define KLTC_CMD_PCOEF     4
`define KLTC_CMD_LCOEF     8

// ************************************************************
// status bits
// ************************************************************
`define KLTC_ST_TRAINED    0
`define KLTC_ST_FLOCK      1
`define KLTC_ST_ACTIVE     2
`define KLTC_ST_FAIL       3
`define KLTC_ST_ERR        4
`define KLTC_ST_FLERR      5
`define KLTC_ST_CTLELOSS   6
`define KLTC_ST_CTLEERR    7
`define KLTC_ST_RESTART    8'h04

// ************************************************************
// codes and window fields
// ************************************************************
`define KLTC_CTLE_OFF      3'h0
`define KLTC_CTLE_ON       3'h3
`define KLTC_DFE_OFF       3'h0
`define KLTC_DFE_END       3'h2
`define KLTC_DFE_TAPS      3'h3
`define KLTC_REQ_HOLD      2'h0
`define KLTC_REQ_INC       2'h1
`define KLTC_REQ_DEC       2'h2
`define KLTC_WIN_F_HI      9
`define KLTC_WIN_K_LO      10
`define KLTC_WIN_K_HI      19
`define KLTC_WIN_F_SIM     10'h003
`define KLTC_WIN_K_HW      10'h00f
`define KLTC_WIN_K_SIM     10'h000
`define KLTC_PCOEF_HI      7
`define KLTC_LCOEF_LO      16
`define KLTC_LCOEF_HI      23

`endif

// ===== verilog/kltc_pkg.sv
// types for the link-training register bank
// assumes kltc_defs.svh is compiled alongside
package kltc_pkg;
    typedef enum logic [1:0] {KLTC_IDLE, KLTC_RUN, KLTC_DONE} kltc_phase_e;
    typedef logic [2:0] kltc_code_t;
endpackage : kltc_pkg

// ===== verilog/kltc_train_regs.sv
// control and status registers of the backplane link-training engine
// assumes a synchronous word-addressed register port and engine status levels
//
// The strobed register port was left to the implementer.
`include "kltc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module kltc_train_regs
    import kltc_pkg::*;
#(
    parameter bit SIM_DEFAULTS = 1'b0
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    // engine status inputs (levels)
    input  wire logic        engRxTrained,
    input  wire logic        engFrameLock,
    input  wire logic        engDone,
    input  wire logic        engFail,
    input  wire logic        engBerErr,
    input  wire logic        engCtlePhase,
    input  wire logic        engCtleSat,
    // engine controls
    output logic             trainRestart,
    output logic             ctleTuneEn,
    output logic             swingHigh,
    output logic       [1:0] dfeTrigger,
    output logic             maxEqMode,
    output logic       [2:0] maxPostStep,
    output logic             partnerSend,
    output logic       [7:0] partnerReq,
    output logic             localApply,
    output logic       [7:0] localTaps,
    output logic      [19:0] berWindow
);

    // ************************************************************
    // address decode
    // ************************************************************
    wire logic hitCfg  = (regAddr == `KLTC_OFF_CFG);
    wire logic hitCmd  = (regAddr == `KLTC_OFF_CMD);
    wire logic hitStat = (regAddr == `KLTC_OFF_STAT);
    wire logic hitWin  = (regAddr == `KLTC_OFF_WIN);
    wire logic hitUpd  = (regAddr == `KLTC_OFF_UPD);

    logic [31:0] cfg_r;
    logic [19:0] win_r;
    logic [23:0] upd_r;
    logic  [7:0] stat_r;
    kltc_phase_e phase_r;

    wire logic wrCfg = regWr && hitCfg;
    wire logic wrWin = regWr && hitWin;
    wire logic wrUpd = regWr && hitUpd;
    // strobes are not stored: they act once and read back zero
    wire logic restartHit = regWr && hitCmd && regWdata[`KLTC_CMD_RESTART];
    wire logic pcoefHit   = regWr && hitCmd && regWdata[`KLTC_CMD_PCOEF]
                            && cfg_r[`KLTC_CFG_POVR];
    wire logic lcoefHit   = regWr && hitCmd && regWdata[`KLTC_CMD_LCOEF]
                            && cfg_r[`KLTC_CFG_LOVR];

    // ************************************************************
    // writable registers
    // ************************************************************
    wire logic [9:0] winKRst = SIM_DEFAULTS ? `KLTC_WIN_K_SIM : `KLTC_WIN_K_HW;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= `KLTC_CFG_RST;
            upd_r <= 24'h00_0000;
        end else begin
            if (wrCfg) cfg_r <= regWdata;
            if (wrUpd) upd_r <= regWdata[`KLTC_LCOEF_HI:0];
        end
    end

    // window reset differs per build; caught on first clocked cycle after release
    logic winInit_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            win_r     <= 20'h0_0000;
            winInit_r <= 1'b0;
        end else begin
            winInit_r <= 1'b1;
            if (!winInit_r) win_r <= {winKRst, `KLTC_WIN_F_SIM};
            else if (wrWin) win_r <= regWdata[`KLTC_WIN_K_HI:0];
        end
    end

    // ************************************************************
    // status tracking
    // ************************************************************
    logic [7:0] stat_nxt;
    always_comb begin
        stat_nxt = stat_r;
        stat_nxt[`KLTC_ST_TRAINED] = engRxTrained;
        stat_nxt[`KLTC_ST_FLOCK]   = engFrameLock;
        stat_nxt[`KLTC_ST_ACTIVE]  = (phase_r == KLTC_RUN);
        stat_nxt[`KLTC_ST_FAIL]    = engFail;
        stat_nxt[`KLTC_ST_ERR]     = engBerErr;
        if (phase_r == KLTC_RUN && stat_r[`KLTC_ST_FLOCK] && !engFrameLock)
            stat_nxt[`KLTC_ST_FLERR] = 1'b1;
        if (engCtlePhase && stat_r[`KLTC_ST_FLOCK] && !engFrameLock)
            stat_nxt[`KLTC_ST_CTLELOSS] = 1'b1;
        if (engCtlePhase && engCtleSat)
            stat_nxt[`KLTC_ST_CTLEERR] = 1'b1;
        // engine levels lag the restart pulse by a cycle, so they are stale then
        if (restartHit || trainRestart) stat_nxt = `KLTC_ST_RESTART;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stat_r  <= 8'h00;
            phase_r <= KLTC_IDLE;
        end else begin
            stat_r <= stat_nxt;
            case (phase_r)
                KLTC_IDLE: phase_r <= KLTC_RUN;
                // a stale done level during the restart pulse must not end the run
                KLTC_RUN:  if (engDone && !restartHit && !trainRestart) phase_r <= KLTC_DONE;
                KLTC_DONE: if (restartHit) phase_r <= KLTC_RUN;
                default:   phase_r <= KLTC_IDLE;
            endcase
        end
    end

    // ************************************************************
    // read path and outputs
    // ************************************************************
    wire logic [31:0] rdMux =
        hitCfg  ? cfg_r :
        hitStat ? {24'h00_0000, stat_r} :
        hitWin  ? {12'h000, win_r} :
        hitUpd  ? {8'h00, upd_r} : 32'h0000_0000;

    wire logic [2:0] ctleCode = cfg_r[`KLTC_CFG_CTLE_HI:`KLTC_CFG_CTLE_LO];
    wire logic [2:0] dfeCode  = cfg_r[`KLTC_CFG_DFE_HI:`KLTC_CFG_DFE_LO];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdata     <= 32'h0000_0000;
            trainRestart <= 1'b0;
            partnerSend  <= 1'b0;
            localApply   <= 1'b0;
            partnerReq   <= 8'h00;
            localTaps    <= 8'h00;
            ctleTuneEn   <= 1'b0;
            swingHigh    <= 1'b0;
            dfeTrigger   <= 2'h0;
            maxEqMode    <= 1'b0;
            maxPostStep  <= 3'h0;
            berWindow    <= 20'h0_0000;
        end else begin
            regRdata     <= regRd ? rdMux : 32'h0000_0000;
            trainRestart <= restartHit;
            partnerSend  <= pcoefHit;
            localApply   <= lcoefHit;
            if (pcoefHit) partnerReq <= upd_r[`KLTC_PCOEF_HI:0];
            if (lcoefHit) localTaps  <= upd_r[`KLTC_LCOEF_HI:`KLTC_LCOEF_LO];
            ctleTuneEn   <= (ctleCode == `KLTC_CTLE_ON);
            swingHigh    <= cfg_r[`KLTC_CFG_SWING];
            // reserved codes fall back to disabled
            dfeTrigger   <= (dfeCode == `KLTC_DFE_END)  ? 2'h1 :
                            (dfeCode == `KLTC_DFE_TAPS) ? 2'h2 : 2'h0;
            maxEqMode    <= cfg_r[`KLTC_CFG_MAXEQ];
            maxPostStep  <= cfg_r[`KLTC_CFG_PSTEP_HI:`KLTC_CFG_PSTEP_LO];
            berWindow    <= win_r;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_RESTART_PULSE: assert property (@(posedge clock) disable iff (!rstn)
        restartHit |=> trainRestart ##1 (!trainRestart || $past(restartHit)))
        else $error("restart strobe not a single pulse");
    AST_PCOEF_GATE: assert property (@(posedge clock) disable iff (!rstn)
        partnerSend |-> $past(cfg_r[`KLTC_CFG_POVR]) && $past(regWr))
        else $error("partner send without override enable");
    AST_LCOEF_GATE: assert property (@(posedge clock) disable iff (!rstn)
        localApply |-> $past(cfg_r[`KLTC_CFG_LOVR])
            && localTaps == $past(upd_r[`KLTC_LCOEF_HI:`KLTC_LCOEF_LO]))
        else $error("local apply wrong gate or data");
    AST_CTLE_EN: assert property (@(posedge clock) disable iff (!rstn)
        ctleTuneEn |-> $past(ctleCode) == `KLTC_CTLE_ON)
        else $error("ctle tuning enabled by wrong code");
    AST_TRAINED: assert property (@(posedge clock) disable iff (!rstn)
        ##1 !$past(restartHit) && !$past(trainRestart)
            |-> stat_r[`KLTC_ST_TRAINED] == $past(engRxTrained))
        else $error("trained flag does not follow engine");
    AST_RESTART_CLR: assert property (@(posedge clock) disable iff (!rstn)
        restartHit |=> stat_r == `KLTC_ST_RESTART && phase_r == KLTC_RUN)
        else $error("restart did not clear status");
    AST_RESTART_HOLD: assert property (@(posedge clock) disable iff (!rstn)
        trainRestart |=> stat_r == `KLTC_ST_RESTART && phase_r == KLTC_RUN)
        else $error("stale engine status after restart");
    AST_DFE_OFF: assert property (@(posedge clock) disable iff (!rstn)
        $past(dfeCode) == `KLTC_DFE_OFF |-> dfeTrigger == 2'h0)
        else $error("dfe triggered while disabled");
    AST_POST_STEP: assert property (@(posedge clock) disable iff (!rstn)
        maxPostStep == $past(cfg_r[`KLTC_CFG_PSTEP_HI:`KLTC_CFG_PSTEP_LO]))
        else $error("post step limit does not follow config");
    AST_WIN_FOLLOW: assert property (@(posedge clock) disable iff (!rstn)
        berWindow == $past(win_r))
        else $error("error window does not follow register");
    AST_ACTIVE: assert property (@(posedge clock) disable iff (!rstn)
        phase_r == KLTC_DONE |=> !stat_r[`KLTC_ST_ACTIVE] || $past(restartHit))
        else $error("active flag set after completion");
    AST_CTLE_ERR: assert property (@(posedge clock) disable iff (!rstn)
        engCtlePhase && engCtleSat && !restartHit && !trainRestart
            |=> stat_r[`KLTC_ST_CTLEERR])
        else $error("ctle tuning error not flagged");

endmodule : kltc_train_regs
`default_nettype wire

// ===== test/kltc_engine_model.sv
// behavioural training engine that feeds status levels to the bank
// assumes trainRestart is a one-cycle pulse from the bank
`timescale 1ns/10ps
`default_nettype none
module kltc_engine_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // restart and chosen faults
    input  wire logic       trainRestart,
    input  wire logic [3:0] faultSel,
    // status levels
    output logic            engRxTrained,
    output logic            engFrameLock,
    output logic            engDone,
    output logic            engFail,
    output logic            engBerErr,
    output logic            engCtlePhase,
    output logic            engCtleSat
);
    logic [7:0] step_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            step_r <= 8'h00;
        else if (trainRestart)
            step_r <= 8'h00;
        else if (step_r != 8'hff)
            step_r <= step_r + 8'h01;
    end
    // fault 0 drops lock for three steps inside the CTLE phase
    wire logic dropWin = faultSel[0] && step_r >= 8'h0a && step_r <= 8'h0c;
    assign engFrameLock = step_r >= 8'h04 && !dropWin;
    assign engCtlePhase = step_r >= 8'h04 && step_r < 8'h10;
    assign engCtleSat   = faultSel[1] && engCtlePhase;
    assign engRxTrained = step_r >= 8'h14;
    assign engDone      = step_r >= 8'h18;
    assign engFail      = faultSel[2] && engDone;
    assign engBerErr    = faultSel[3] && engDone;
endmodule : kltc_engine_model
`default_nettype wire

// ===== test/testbench.sv
// random and corner tests of the link-training register bank
// assumes the engine model in kltc_engine_model.sv
`include "kltc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin checkCount++; if ((gt) !== (ex)) begin errTotal++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module testbench;
    logic clock, rstn, regWr, regRd, trainRestart, ctleTuneEn, swingHigh, maxEqMode;
    logic partnerSend, localApply;
    logic [1:0] dfeTrigger;
    logic [2:0] maxPostStep;
    logic [3:0] faultSel;
    logic [7:0] regAddr, partnerReq, localTaps;
    logic [19:0] berWindow;
    logic [31:0] regWdata, regRdata, v, upd, d;
    logic eTr, eFl, eDn, eFa, eBe, eCp, eCs;
    integer seed, errTotal, checkCount;
    kltc_train_regs #(.SIM_DEFAULTS(1'b0)) kltc_train_regs_inst (.clock(clock), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .engRxTrained(eTr), .engFrameLock(eFl), .engDone(eDn),
        .engFail(eFa), .engBerErr(eBe), .engCtlePhase(eCp), .engCtleSat(eCs),
        .trainRestart(trainRestart), .ctleTuneEn(ctleTuneEn), .swingHigh(swingHigh),
        .dfeTrigger(dfeTrigger), .maxEqMode(maxEqMode), .maxPostStep(maxPostStep),
        .partnerSend(partnerSend), .partnerReq(partnerReq), .localApply(localApply),
        .localTaps(localTaps), .berWindow(berWindow));
    kltc_engine_model kltc_engine_model_inst (.clock(clock), .rstn(rstn),
        .trainRestart(trainRestart), .faultSel(faultSel), .engRxTrained(eTr),
        .engFrameLock(eFl), .engDone(eDn), .engFail(eFa), .engBerErr(eBe),
        .engCtlePhase(eCp), .engCtleSat(eCs));
    // ****
    // bus tasks and expectations
    // ****
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge clock);
        regAddr <= a;
        regWdata <= x;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        q = regRdata;
    endtask : rd
    function automatic logic [31:0] expStat(input logic [3:0] f);
        return {24'h0, f[1], f[0], f[0], f[3], f[2], 3'b011};
    endfunction : expStat
    task automatic conclude;
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        errTotal++;
        conclude();
    end
    // ****
    // main sequence
    // ****
    initial begin
        {rstn, regWr, regRd, regAddr, regWdata, faultSel} = '0;
        seed = 74946;
        errTotal = 0;
        checkCount = 0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (40) @(posedge clock);
        rd(`KLTC_OFF_CFG, d);
        `CHK("cfg", 32'h0, d)
        rd(`KLTC_OFF_WIN, d);
        `CHK("win", {12'h0, `KLTC_WIN_K_HW, `KLTC_WIN_F_SIM}, d)
        `CHK("berWindow", {`KLTC_WIN_K_HW, `KLTC_WIN_F_SIM}, berWindow)
        rd(`KLTC_OFF_STAT, d);
        `CHK("stat", 32'h3, d)
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            v[22:20] = (i % 2) ? `KLTC_CTLE_ON : `KLTC_CTLE_OFF;
            v[26:24] = (i % 3 == 0) ? `KLTC_DFE_OFF : (i % 3 == 1) ? `KLTC_DFE_END : `KLTC_DFE_TAPS;
            wr(`KLTC_OFF_CFG, v);
            rd(`KLTC_OFF_CFG, d);
            `CHK("cfg", v, d)
            `CHK("ctleTuneEn", 1'(i % 2), ctleTuneEn)
            `CHK("swingHigh", v[23], swingHigh)
            `CHK("dfeTrigger", 2'(i % 3), dfeTrigger)
            `CHK("maxEqMode", v[28], maxEqMode)
            `CHK("maxPostStep", v[31:29], maxPostStep)
        end
        v = $random(seed);
        wr(`KLTC_OFF_WIN, v);
        rd(`KLTC_OFF_WIN, d);
        `CHK("win", v[19:0], d[19:0])
        `CHK("berWindow", v[19:0], berWindow)
        rd(8'h10, d);
        `CHK("unmapped", 32'h0, d)
        rd(`KLTC_OFF_CMD, d);
        `CHK("cmd", 32'h0, d)
        $display("test config done");
        upd = $random(seed);
        upd[5:0] = {`KLTC_REQ_INC, `KLTC_REQ_DEC, `KLTC_REQ_HOLD};
        wr(`KLTC_OFF_CFG, 32'h0);
        wr(`KLTC_OFF_UPD, upd);
        wr(`KLTC_OFF_CMD, 32'h0000_0110);
        repeat (2) begin
            @(negedge clock);
            `CHK("partnerSend", 1'b0, partnerSend)
            `CHK("localApply", 1'b0, localApply)
        end
        wr(`KLTC_OFF_CFG, 32'h0003_0000);
        wr(`KLTC_OFF_CMD, 32'h0000_0110);
        @(negedge clock);
        `CHK("partnerSend", 1'b1, partnerSend)
        `CHK("partnerReq", upd[7:0], partnerReq)
        `CHK("localApply", 1'b1, localApply)
        `CHK("localTaps", upd[23:16], localTaps)
        @(negedge clock);
        `CHK("partnerSend", 1'b0, partnerSend)
        `CHK("localApply", 1'b0, localApply)
        $display("test override done");
        for (int f = 1; f >= 0; f--) begin
            @(posedge clock);
            faultSel <= f ? 4'hf : 4'h0;
            wr(`KLTC_OFF_CMD, 32'h1);
            @(negedge clock);
            `CHK("trainRestart", 1'b1, trainRestart)
            @(negedge clock);
            `CHK("trainRestart", 1'b0, trainRestart)
            // stale engine levels must not leak into status just after restart
            rd(`KLTC_OFF_STAT, d);
            `CHK("stat", 32'h4, d)
            repeat (40) @(posedge clock);
            wr(`KLTC_OFF_STAT, 32'hffff_ffff);
            rd(`KLTC_OFF_STAT, d);
            `CHK("stat", expStat(f ? 4'hf : 4'h0), d)
        end
        $display("test status done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
